// file: hdl/tx_pattern_pkg.sv
// shared constants, types and helpers for the transmit pattern port
package tx_pattern_pkg;
  // register indices on the four-bit host address
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_WORD0  = 4'h1;
  localparam logic [3:0] REG_WORD3  = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  // control field positions and reset values
  localparam int unsigned CTRL_WIDTH_LSB = 0;
  localparam int unsigned CTRL_PAT_LSB   = 2;
  localparam int unsigned CTRL_NB_LSB    = 5;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam logic [7:0]  WORD_RST       = 8'h00;
  // status bit positions
  localparam int unsigned STAT_BUSY      = 0;
  localparam int unsigned STAT_RESTART   = 1;
  localparam int unsigned STAT_GATE      = 2;
  // idle value of the synchronised host pins {sel_n, rd_n, wr_n, addr, data}
  localparam logic [14:0] HB_IDLE        = 15'h7000;
  // interface width codes
  localparam logic [1:0]  WIDTH_SERIAL   = 2'h0;
  localparam logic [1:0]  WIDTH_NIBBLE   = 2'h1;
  localparam logic [1:0]  WIDTH_BYTE     = 2'h2;
  // pattern codes
  localparam logic [2:0]  PAT_PRBS15     = 3'h0;
  localparam logic [2:0]  PAT_PRBS20     = 3'h1;
  localparam logic [2:0]  PAT_PRBS23     = 3'h2;
  localparam logic [2:0]  PAT_ONES       = 3'h3;
  localparam logic [2:0]  PAT_ZEROS      = 3'h4;
  localparam logic [2:0]  PAT_ALT10      = 3'h5;
  localparam logic [2:0]  PAT_ALT1100    = 3'h6;
  localparam logic [2:0]  PAT_PROG       = 3'h7;
  // generator lengths and feedback taps
  localparam logic [4:0]  PRBS15_LEN     = 5'h0F;
  localparam logic [4:0]  PRBS15_TAP     = 5'h0E;
  localparam logic [4:0]  PRBS20_LEN     = 5'h14;
  localparam logic [4:0]  PRBS20_TAP     = 5'h11;
  localparam logic [4:0]  PRBS23_LEN     = 5'h17;
  localparam logic [4:0]  PRBS23_TAP     = 5'h12;
  localparam logic [22:0] PRBS_ONES      = 23'h7F_FFFF;
  // fixed words, sent most significant bit first
  localparam logic [31:0] ONES_WORD      = 32'h0000_0001;
  localparam logic [31:0] ZEROS_WORD     = 32'h0000_0000;
  localparam logic [31:0] ALT10_WORD     = 32'h0000_0002;
  localparam logic [31:0] ALT1100_WORD   = 32'h0000_000C;
  localparam logic [5:0]  ONE_LEN        = 6'h01;
  localparam logic [5:0]  ALT10_LEN      = 6'h02;
  localparam logic [5:0]  ALT1100_LEN    = 6'h04;
  localparam logic [5:0]  BYTE_LEN       = 6'h08;

  // settings as the link side uses them
  typedef struct packed {
    logic [1:0]  width;    // serial, nibble or byte
    logic        is_prbs;  // pseudo-random rather than word
    logic [4:0]  plen;     // generator length
    logic [4:0]  ptap;     // feedback tap
    logic [31:0] word;     // word pattern, low wlen bits used
    logic [5:0]  wlen;     // word pattern length in bits
  } tx_cfg_t;

  localparam tx_cfg_t CFG_RST = '{width: WIDTH_SERIAL, is_prbs: 1'b1, plen: PRBS15_LEN,
                                  ptap: PRBS15_TAP, word: ZEROS_WORD, wlen: ONE_LEN};

  // bits per strobe for a width code; code 3 acts as byte
  function automatic logic [3:0] width_bits(input logic [1:0] w);
    return (w == WIDTH_SERIAL) ? 4'h1 : (w == WIDTH_NIBBLE) ? 4'h4 : 4'h8;
  endfunction

  // output lanes in use for a width code
  function automatic logic [7:0] width_mask(input logic [1:0] w);
    return (w == WIDTH_SERIAL) ? 8'h01 : (w == WIDTH_NIBBLE) ? 8'h0F : 8'hFF;
  endfunction
endpackage

// file: hdl/tx_gen_if.sv
// bundle between the port's crossing logic and its pattern engine
`timescale 1ns/1ps
interface tx_gen_if;
  import tx_pattern_pkg::*;
  tx_cfg_t    cfg;         // settings, already in the link domain
  logic       gate;        // link clock gate level
  logic       restart_n;   // pattern restart pin level
  logic [7:0] word;        // next word, latest bit in bit 0
  logic       restart_tg;  // toggles on each accepted restart
  modport gen  (input cfg, gate, restart_n, output word, restart_tg);
  modport port (output cfg, gate, restart_n, input word, restart_tg);
endinterface // tx_gen_if

// file: hdl/tx_pattern_gen.sv
// pattern engine on the transmit clock: pseudo-random or word stream
`timescale 1ns/1ps
module tx_pattern_gen
  import tx_pattern_pkg::*;
(
  // link clock and its synchronised reset
  input logic      tx_time_base,
  input logic      tx_rst_n,
  // settings, pins and next word
  tx_gen_if.gen    g
);
  // one strobe's worth of bits: returns {word, generator, word index}
  function automatic logic [35:0] advance(input tx_cfg_t c, input logic [22:0] s_in,
                                          input logic [4:0] i_in);
    logic [22:0] s;
    logic [4:0]  i;
    logic [7:0]  w;
    logic        b;
    logic [3:0]  n;
    s = s_in;
    i = i_in;
    w = 8'h00;
    b = 1'b0;
    n = width_bits(c.width);
    for (int k = 0; k < 8; k++)
    begin
      if (4'(k) < n)
      begin
        if (c.is_prbs)
        begin
          // oldest stage goes out, so a freshly loaded generator starts with ones
          b = s[c.plen - 5'h01];
          s = {s[21:0], s[c.plen - 5'h01] ^ s[c.ptap - 5'h01]};
        end
        else
        begin
          b = c.word[i];
          i = (i == 5'h00) ? 5'(c.wlen - 6'h01) : i - 5'h01;
        end
        // shift upward so the newest bit lands in bit 0
        w = {w[6:0], b};
      end
    end
    return {w, s, i};
  endfunction

  logic [22:0] lfsr_q;   // generator stages
  logic [4:0]  idx_q;    // position inside the word pattern
  logic [7:0]  word_q;   // word for the next strobe
  logic        tog_q;    // restart event toggle
  logic [35:0] nxt;      // advanced state
  logic        restart;  // restart honoured this edge

  assign nxt     = advance(g.cfg, lfsr_q, idx_q);
  assign restart = !g.restart_n && g.cfg.is_prbs;

  // advance only on gated transmit edges
  always_ff @(posedge tx_time_base or negedge tx_rst_n)
  begin
    if (!tx_rst_n)
    begin
      lfsr_q <= PRBS_ONES;
      idx_q  <= 5'h00;
      word_q <= 8'h00;
      tog_q  <= 1'b0;
    end
    else if (g.gate)
    begin
      if (restart)
      begin
        lfsr_q <= PRBS_ONES;
        tog_q  <= !tog_q;
      end
      else
      begin
        {word_q, lfsr_q, idx_q} <= nxt;
      end
    end
  end

  assign g.word       = word_q;
  assign g.restart_tg = tog_q;

  chk_restart_loads: assert property (
    @(posedge tx_time_base) disable iff (!tx_rst_n)
    (g.gate && restart) |=> (lfsr_q == PRBS_ONES))
    else $error("restart did not load all ones");

  chk_restart_ignored: assert property (
    @(posedge tx_time_base) disable iff (!tx_rst_n)
    (g.gate && !g.restart_n && !g.cfg.is_prbs) |=> $stable(tog_q))
    else $error("restart taken in word mode");

  chk_gate_hold: assert property (
    @(posedge tx_time_base) disable iff (!tx_rst_n)
    !g.gate |=> ($stable(word_q) && $stable(lfsr_q) && $stable(idx_q)))
    else $error("generator moved while gated off");

  chk_start_ones: assert property (
    @(posedge tx_time_base) disable iff (!tx_rst_n)
    (g.gate && restart ##1 g.gate && !restart) |=> (word_q == width_mask(g.cfg.width)))
    else $error("sequence start is not a run of ones");
endmodule // tx_pattern_gen

// file: hdl/test_pattern_tx_port.sv
// transmit pattern port: host register bus, clock crossing and link output stage
//
// Function
// - transmit clock alone advances and shifts data
// - gate high advances, gate low ignores edges
// - output strobe derived from transmit clock
// - data changes on strobe falling edge
// - no strobe pulses while gate low
// - bit 0 carries serial data and lsb
// - lsb holds latest bit, older bits higher
// - nibble mode drives bits three to zero
// - byte mode drives bits seven to zero
// - restart low returns generator to start
// - sequence starts with a run of ones
// - start appears one and half cycles later
// - restart ignored for fixed or programmed words
// - transfers only while select is low
// - select and read low return register data
// - select and write low store bus data
// - four address bits pick sixteen locations
// - eight bit bus, bit seven most significant
// - one width setting for both paths
// - restart loads every generator stage with one
// - one pattern choice shared by both paths
`timescale 1ns/1ps
module test_pattern_tx_port
  import tx_pattern_pkg::*;
(
  // host clock and reset
  input  logic       clk,
  input  logic       nrst,
  // host register bus, strobes active low
  input  logic       sel_n,
  input  logic       rd_n,
  input  logic       wr_n,
  input  logic [3:0] addr,
  input  logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic       data_oe,
  // transmit link
  input  logic       tx_time_base,
  input  logic       tx_clock_gate,
  input  logic       tx_pattern_restart_n,
  output logic       tx_out_strobe,
  output logic [7:0] tx_par_data
);

  // ---------------- host side ----------------

  logic [14:0] hs1_q;   // first stage, read only by the second
  logic [14:0] hs2_q;   // synchronised host pins

  // host pins are asynchronous to clk: two flops before any use
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hs1_q <= HB_IDLE;
      hs2_q <= HB_IDLE;
    end
    else
    begin
      hs1_q <= {sel_n, rd_n, wr_n, addr, data_in};
      hs2_q <= hs1_q;
    end
  end

  logic       sel_s;    // select, synchronised
  logic       rd_s;     // read strobe, synchronised
  logic       wr_s;     // write strobe, synchronised
  logic [3:0] addr_s;   // address, synchronised
  logic [7:0] din_s;    // bus data, synchronised
  logic       rd_act;   // selected read in progress
  logic       wr_act;   // selected write in progress

  assign {sel_s, rd_s, wr_s, addr_s, din_s} = hs2_q;
  assign rd_act = !sel_s && !rd_s;
  assign wr_act = !sel_s && !wr_s;

  logic       wr_act_q;  // write active last cycle
  logic [3:0] wa_q;      // address held during the write
  logic [7:0] wd_q;      // data held during the write
  logic       wr_end;    // write strobe just ended

  // track address and data while the write is active; commit at its end,
  // when the host data has long settled through the synchroniser
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_act_q <= 1'b0;
      wa_q     <= 4'h0;
      wd_q     <= 8'h00;
    end
    else
    begin
      wr_act_q <= wr_act;
      if (wr_act)
      begin
        wa_q <= addr_s;
        wd_q <= din_s;
      end
    end
  end

  assign wr_end = wr_act_q && !wr_act;

  logic [7:0] ctrl_q;       // width, pattern and word length
  logic [7:0] pword_q [4];  // programmable word bytes, first sent first
  logic       wr_word;      // write lands in a word byte
  logic [1:0] wsel;         // which word byte

  assign wr_word = (wa_q >= REG_WORD0) && (wa_q <= REG_WORD3);
  assign wsel    = 2'(wa_q - REG_WORD0);

  // register file; the status location and unused locations ignore writes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= CTRL_RST;
      for (int k = 0; k < 4; k++)
      begin
        pword_q[k] <= WORD_RST;
      end
    end
    else if (wr_end)
    begin
      if (wa_q == REG_CTRL)
      begin
        ctrl_q <= wd_q;
      end
      else if (wr_word)
      begin
        pword_q[wsel] <= wd_q;
      end
    end
  end

  logic       tog_w;  // restart toggle from the link engine
  logic [2:0] ba1_q;  // first stage: {ack, restart toggle, gate}
  logic [2:0] ba2_q;  // synchronised link-side state
  logic       req_q;  // settings request toggle
  logic       busy;   // link side has not taken the last settings

  assign busy = req_q != ba2_q[2];

  // status image; bit 7 down to 3 read as zero
  logic [7:0] stat;
  always_comb
  begin
    stat               = 8'h00;
    stat[STAT_BUSY]    = busy;
    stat[STAT_RESTART] = ba2_q[1];
    stat[STAT_GATE]    = ba2_q[0];
  end

  logic       rd_word;  // read addresses a word byte
  logic [7:0] rmux;     // addressed register contents
  logic [7:0] rdata_q;  // registered read data

  assign rd_word = (addr_s >= REG_WORD0) && (addr_s <= REG_WORD3);
  assign rmux    = (addr_s == REG_CTRL)   ? ctrl_q :
                   rd_word                ? pword_q[2'(addr_s - REG_WORD0)] :
                   (addr_s == REG_STATUS) ? stat : 8'h00;

  // read data is refreshed every cycle so it follows the address
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rmux;
    end
  end

  assign data_out = rdata_q;
  assign data_oe  = rd_act;

  chk_write_commit: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_end && wa_q == REG_CTRL) |=> (ctrl_q == $past(wd_q)))
    else $error("control write not stored");

  chk_read_data: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd_act ##1 rd_act) |-> (data_oe && data_out == $past(rmux)))
    else $error("read returned wrong data");

  chk_bus_release: assert property (
    @(posedge clk) disable iff (!nrst)
    data_oe == (!$past(sel_n, 2) && !$past(rd_n, 2)))
    else $error("bus driven while deselected");

  // ---------------- settings for the link side ----------------

  logic [2:0]  pat;        // pattern code
  logic [1:0]  nb;         // word bytes minus one
  logic [31:0] pword_all;  // first nb+1 bytes, first byte highest

  assign pat       = ctrl_q[CTRL_PAT_LSB +: 3];
  assign nb        = ctrl_q[CTRL_NB_LSB +: 2];
  assign pword_all = {pword_q[0], pword_q[1], pword_q[2], pword_q[3]} >> {2'h3 - nb, 3'h0};

  tx_cfg_t cfg_new;  // settings as the registers stand now

  // one width and one pattern choice, shared by every path
  always_comb
  begin
    cfg_new         = CFG_RST;
    cfg_new.width   = ctrl_q[CTRL_WIDTH_LSB +: 2];
    cfg_new.is_prbs = (pat == PAT_PRBS15) || (pat == PAT_PRBS20) || (pat == PAT_PRBS23);
    unique case (pat)
      PAT_PRBS15:
      begin
        cfg_new.plen = PRBS15_LEN;
        cfg_new.ptap = PRBS15_TAP;
      end
      PAT_PRBS20:
      begin
        cfg_new.plen = PRBS20_LEN;
        cfg_new.ptap = PRBS20_TAP;
      end
      PAT_PRBS23:
      begin
        cfg_new.plen = PRBS23_LEN;
        cfg_new.ptap = PRBS23_TAP;
      end
      PAT_ONES:
      begin
        cfg_new.word = ONES_WORD;
        cfg_new.wlen = ONE_LEN;
      end
      PAT_ZEROS:
      begin
        cfg_new.word = ZEROS_WORD;
        cfg_new.wlen = ONE_LEN;
      end
      PAT_ALT10:
      begin
        cfg_new.word = ALT10_WORD;
        cfg_new.wlen = ALT10_LEN;
      end
      PAT_ALT1100:
      begin
        cfg_new.word = ALT1100_WORD;
        cfg_new.wlen = ALT1100_LEN;
      end
      PAT_PROG:
      begin
        cfg_new.word = pword_all;
        cfg_new.wlen = 6'({nb, 3'h0}) + BYTE_LEN;
      end
    endcase
  end

  tx_cfg_t shadow_q;  // settings offered to the link side, held stable
  logic    ack_q;     // link-side acknowledge toggle

  // four-phase-free toggle handshake: shadow only changes once the link side
  // has taken the previous copy, so it is stable whenever sampled there;
  // a stopped link clock simply leaves the last request pending
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shadow_q <= CFG_RST;
      req_q    <= 1'b0;
      ba1_q    <= 3'h0;
      ba2_q    <= 3'h0;
    end
    else
    begin
      ba1_q <= {ack_q, tog_w, tx_clock_gate};
      ba2_q <= ba1_q;
      if (!busy && shadow_q != cfg_new)
      begin
        shadow_q <= cfg_new;
        req_q    <= !req_q;
      end
    end
  end

  // ---------------- link side ----------------

  logic trst1_q;     // reset release, first stage
  logic tx_rst_n_q;  // link-domain reset, released on the link clock

  // reset asserts at once and releases cleanly on the link clock
  always_ff @(posedge tx_time_base or negedge nrst)
  begin
    if (!nrst)
    begin
      trst1_q    <= 1'b0;
      tx_rst_n_q <= 1'b0;
    end
    else
    begin
      trst1_q    <= 1'b1;
      tx_rst_n_q <= trst1_q;
    end
  end

  logic    rq1_q;      // request toggle, first stage
  logic    rq2_q;      // request toggle, synchronised
  tx_cfg_t cfg_act_q;  // settings in force on the link

  // take the shadow copy when a new request toggle arrives
  always_ff @(posedge tx_time_base or negedge tx_rst_n_q)
  begin
    if (!tx_rst_n_q)
    begin
      rq1_q     <= 1'b0;
      rq2_q     <= 1'b0;
      ack_q     <= 1'b0;
      cfg_act_q <= CFG_RST;
    end
    else
    begin
      rq1_q <= req_q;
      rq2_q <= rq1_q;
      ack_q <= rq2_q;
      if (rq2_q != ack_q)
      begin
        cfg_act_q <= shadow_q;
      end
    end
  end

  chk_cfg_stable: assert property (
    @(posedge tx_time_base) disable iff (!tx_rst_n_q)
    !$stable(cfg_act_q) |-> $past(rq2_q != ack_q))
    else $error("link settings changed without a request");

  // pattern engine; gate and restart meet the link clock's own timing
  tx_gen_if g ();

  assign g.cfg       = cfg_act_q;
  assign g.gate      = tx_clock_gate;
  assign g.restart_n = tx_pattern_restart_n;
  assign tog_w       = g.restart_tg;

  tx_pattern_gen u_gen (
    .tx_time_base (tx_time_base),
    .tx_rst_n     (tx_rst_n_q),
    .g            (g.gen)
  );

  logic       rise_q;  // toggles on each gated rising edge
  logic       fall_q;  // follows rise_q on the falling edge
  logic [7:0] out_q;   // data presented on the link

  // a gated rising edge opens a strobe pulse; an ungated one leaves a gap
  always_ff @(posedge tx_time_base or negedge tx_rst_n_q)
  begin
    if (!tx_rst_n_q)
    begin
      rise_q <= 1'b0;
    end
    else if (tx_clock_gate)
    begin
      rise_q <= !rise_q;
    end
  end

  // the falling edge closes the pulse and moves the data with it
  always_ff @(negedge tx_time_base or negedge tx_rst_n_q)
  begin
    if (!tx_rst_n_q)
    begin
      fall_q <= 1'b0;
      out_q  <= 8'h00;
    end
    else
    begin
      fall_q <= rise_q;
      if (rise_q ^ fall_q)
      begin
        out_q <= g.word;
      end
    end
  end

  // only one of the two flops moves at a time, so the strobe cannot glitch
  assign tx_out_strobe = rise_q ^ fall_q;
  assign tx_par_data   = out_q;

  chk_strobe_gap: assert property (
    @(posedge tx_time_base) disable iff (!tx_rst_n_q)
    !tx_clock_gate |=> (rise_q == $past(rise_q)))
    else $error("strobe pulse while gated off");

  chk_out_follows: assert property (
    @(negedge tx_time_base) disable iff (!tx_rst_n_q)
    tx_out_strobe |=> (tx_par_data == $past(g.word)))
    else $error("data did not move on strobe fall");

  chk_nibble_upper: assert property (
    @(negedge tx_time_base) disable iff (!tx_rst_n_q)
    (cfg_act_q.width == WIDTH_NIBBLE)[*3] |-> (tx_par_data[7:4] == 4'h0))
    else $error("upper lanes active in nibble mode");
endmodule // test_pattern_tx_port

// file: tb/tx_link_sink.sv
// link-side receiver model that captures one word per output strobe
`timescale 1ns/1ps
module tx_link_sink
(
  // link pins from the port
  input  wire logic       tx_out_strobe,
  input  wire logic [7:0] tx_par_data,
  // captured word and a toggle per capture
  output logic      [7:0] got,
  output logic            got_tg
);
  logic [7:0] cap_q;        // word held at the strobe edge
  logic       tg_q = 1'b0;  // capture toggle, driven by one process only

  assign got_tg = tg_q;

  // sample on the rising edge, half a cycle after the data moved;
  // the delay keeps the monitor clear of the edge's own updates
  always @(posedge tx_out_strobe)
  begin
    cap_q = tx_par_data;
    #1;
    got    = cap_q;
    tg_q   = ~tg_q;
  end
endmodule // tx_link_sink

// file: tb/tb.sv
// self-checking bench for the transmit pattern port
`timescale 1ns/1ps
module tb;
  import tx_pattern_pkg::*;
  // host side
  logic       clk = 1'b0, nrst = 1'b0;
  logic       sel_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, hb_en = 1'b0, data_oe;
  logic [3:0] addr = 4'h0;
  logic [7:0] hb_d = 8'h00, data_out, bus_w, q;
  // link side
  logic       tx_time_base = 1'b0, tx_clock_gate = 1'b0, tx_pattern_restart_n = 1'b1;
  logic       tx_out_strobe, got_tg, g, link_up = 1'b0;
  logic [7:0] tx_par_data, got;
  // scoreboard
  logic [7:0] exp_q[$];
  int         num_errors = 0, check_count = 0, skip = 0, k;
  // width and pattern pairs, code 3 included on purpose
  logic [1:0] wtab [5] = '{WIDTH_SERIAL, WIDTH_NIBBLE, WIDTH_BYTE, 2'h3, WIDTH_NIBBLE};
  logic [2:0] ptab [5] = '{PAT_PRBS15, PAT_PRBS20, PAT_PRBS23, PAT_ONES, PAT_ZEROS};

  // bus wire: device when enabled, bench when writing, pull-up otherwise
  assign bus_w = data_oe ? data_out : (hb_en ? hb_d : 8'hFF);

  test_pattern_tx_port i_dut (
    .clk(clk), .nrst(nrst), .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_in(bus_w), .data_out(data_out), .data_oe(data_oe),
    .tx_time_base(tx_time_base), .tx_clock_gate(tx_clock_gate),
    .tx_pattern_restart_n(tx_pattern_restart_n), .tx_out_strobe(tx_out_strobe),
    .tx_par_data(tx_par_data));

  tx_link_sink i_sink (.tx_out_strobe(tx_out_strobe), .tx_par_data(tx_par_data),
                       .got(got), .got_tg(got_tg));

  // host clock 10 ns, link clock 80 ns with an unrelated phase
  initial forever #5 clk = ~clk;
  initial
  begin
    #3;
    forever #40 tx_time_base = ~tx_time_base;
  end

  // one comparison, counted
  task check(input string nm, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // counts, verdict and end of run
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one host access: strobe low six cycles, then idle four with data held
  task hbus(input logic wr, input logic sel, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {sel_n, rd_n, wr_n, addr, hb_d, hb_en} <= {~sel, wr, ~wr, a, d, wr};
    repeat (5) @(posedge clk);
    #1 q = data_out;
    check("bus enable", {7'h0, sel & ~wr}, {7'h0, data_oe});
    @(posedge clk);
    {sel_n, rd_n, wr_n} <= 3'b111;
    repeat (4) @(posedge clk);
    hb_en <= 1'b0;
    #1 check("bus released", 8'h00, {7'h0, data_oe});
  endtask

  // selected read compared with its expectation
  task rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e);
    hbus(1'b0, 1'b1, a, 8'h00);
    check(nm, e, q);
  endtask

  // one link edge; gate randomly dropped when asked
  task tx_cycle(input bit rnd);
    @(posedge tx_time_base);
    tx_clock_gate        <= rnd ? ($urandom % 4 != 0) : 1'b1;
    tx_pattern_restart_n <= 1'b1;
  endtask

  // expected words from a restart: own generator, oldest bit leaves first
  task push_exp(input logic [1:0] w, input logic [2:0] p, input int n);
    logic [22:0] lf;
    logic [7:0]  wd, mk;
    int          wb, len, tap;
    lf  = '1;
    wb  = (w == WIDTH_SERIAL) ? 1 : (w == WIDTH_NIBBLE) ? 4 : 8;
    mk  = 8'hFF >> (8 - wb);
    len = (p == PAT_PRBS20) ? PRBS20_LEN : (p == PAT_PRBS23) ? PRBS23_LEN : PRBS15_LEN;
    tap = (p == PAT_PRBS20) ? PRBS20_TAP : (p == PAT_PRBS23) ? PRBS23_TAP : PRBS15_TAP;
    repeat (n)
    begin
      wd = 8'h00;
      repeat (wb)
      begin
        wd = {wd[6:0], lf[len-1]};
        lf = {lf[21:0], lf[len-1] ^ lf[tap-1]};
      end
      exp_q.push_back(p == PAT_ONES ? mk : p == PAT_ZEROS ? 8'h00 : wd & mk);
    end
  endtask

  // restart on a gated edge; three captures still carry older words
  task do_restart(input logic [1:0] w, input logic [2:0] p);
    tx_cycle(1'b0);
    @(posedge tx_time_base);
    tx_pattern_restart_n <= 1'b0;
    skip = 3;
    push_exp(w, p, 24);
    tx_cycle(1'b0);
  endtask

  // compare each captured word with the oldest note
  always @(got_tg)
  begin
    if (skip > 0)
      skip--;
    else if (exp_q.size() > 0)
      check("link word", exp_q.pop_front(), got);
  end

  // strobe pulses only on gated edges
  always @(posedge tx_time_base)
  begin
    g = tx_clock_gate;
    #2;
    if (link_up)
      check("strobe", {7'h0, g}, {7'h0, tx_out_strobe});
  end

  // watchdog well beyond the expected run length
  initial
  begin
    #500_000;
    num_errors++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h8121_b2eb));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) tx_cycle(1'b0);
    link_up = 1'b1;
    rd_chk("ctrl reset", REG_CTRL, CTRL_RST);
    rd_chk("status reset", REG_STATUS, 8'h01 << STAT_GATE);
    rd_chk("unmapped", 4'h9, 8'h00);
    hbus(1'b1, 1'b0, REG_WORD3, 8'h5A);
    rd_chk("unselected write", REG_WORD3, WORD_RST);
    k = $urandom;
    hbus(1'b1, 1'b1, REG_WORD0, k[7:0]);
    rd_chk("word0", REG_WORD0, k[7:0]);
    $display("test bus done");
    for (int i = 0; i < 5; i++)
    begin
      hbus(1'b1, 1'b1, REG_CTRL, {3'h0, ptab[i], wtab[i]});
      rd_chk("ctrl", REG_CTRL, {3'h0, ptab[i], wtab[i]});
      repeat (8) tx_cycle(1'b0);
      do_restart(wtab[i], ptab[i]);
      for (k = 0; k < 300 && exp_q.size() > 0; k++)
        tx_cycle(1'b1);
      check("pending words", 8'h00, 8'(exp_q.size()));
      $display("test link %0d done", i);
    end
    // three pseudo-random restarts taken, two word-mode restarts ignored
    repeat (4) tx_cycle(1'b0);
    rd_chk("status end", REG_STATUS, (8'h01 << STAT_RESTART) | (8'h01 << STAT_GATE));
    $display("test status done");
    give_verdict();
  end
endmodule // tb
